// [verilog/pcd_pkg.sv]
package pcd_pkg;

	localparam int PORT_W = 8;

	// Register map of the override control slave, byte addresses.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PCMASK = 8'h04;
	localparam logic [7:0] REG_PINS   = 8'h08;

	// Field positions inside the control register.
	localparam int CTRL_XMEM_EN  = 0;
	localparam int CTRL_XMM_LO   = 1;
	localparam int CTRL_XMM_HI   = 3;
	localparam int CTRL_SCAN_EN  = 4;
	localparam int CTRL_ASYNC_T2 = 5;
	localparam int CTRL_PCG1_EN  = 6;
	localparam int CTRL_PULL_DIS = 7;

	// Reset values.
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  PCMASK_RST = 8'h00;
	localparam logic [7:0]  PORT_RST   = 8'h00;
	localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

	// Port C pin roles.
	localparam int PC_TDI = 7;
	localparam int PC_TDO = 6;
	localparam int PC_TMS = 5;
	localparam int PC_TCK = 4;

	// Port D pin roles.
	localparam int PD_RD   = 7;
	localparam int PD_WR   = 6;
	localparam int PD_OSCO = 5;
	localparam int PD_OSCI = 4;
	localparam int PD_IRQ1 = 3;
	localparam int PD_IRQ0 = 2;
	localparam int PD_TX   = 1;
	localparam int PD_RX   = 0;

	// Port C pin i is an address pin while the high mask is below this limit.
	localparam logic [3:0] PC_MASK_LIMIT [0:7] = '{4'h7, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

endpackage

// [verilog/pcd_ovr_if.sv]
interface pcd_ovr_if;
	logic [7:0] port_data;
	logic [7:0] port_dir;
	logic       pull_dis;
	logic [7:0] pullup_override_en;
	logic [7:0] pullup_override_val;
	logic [7:0] dir_override_en;
	logic [7:0] dir_override_val;
	logic [7:0] pin_value_override_en;
	logic [7:0] pin_value_override_val;
	logic [7:0] input_en_override_en;
	logic [7:0] input_en_override_val;
	logic [7:0] pin_pullup;
	logic [7:0] pin_oe;
	logic [7:0] pin_out;
	logic [7:0] pin_ie;

	modport ctl (
		output port_data, port_dir, pull_dis,
		output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
		output pin_value_override_en, pin_value_override_val, input_en_override_en, input_en_override_val,
		input  pin_pullup, pin_oe, pin_out, pin_ie
	);
	modport mux (
		input  port_data, port_dir, pull_dis,
		input  pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
		input  pin_value_override_en, pin_value_override_val, input_en_override_en, input_en_override_val,
		output pin_pullup, pin_oe, pin_out, pin_ie
	);
endinterface

// [verilog/pcd_ovr_mux.sv]
module pcd_ovr_mux (
	pcd_ovr_if.mux ov
);
	import pcd_pkg::*;

	wire [7:0] normal_pullup;

	// Plain port pull-up: data bit high on an input pin unless pulls are disabled globally.
	assign normal_pullup = ov.port_data & ~ov.port_dir & ~{PORT_W{ov.pull_dis}};

	// Each override picks its own value when enabled; otherwise pull-up, direction and value follow the port registers and input enable is on.
	// per-pin override select
	assign ov.pin_pullup = (ov.pullup_override_en & ov.pullup_override_val) | (~ov.pullup_override_en & normal_pullup);
	assign ov.pin_oe     = (ov.dir_override_en & ov.dir_override_val) | (~ov.dir_override_en & ov.port_dir);
	assign ov.pin_out    = (ov.pin_value_override_en & ov.pin_value_override_val)
	                     | (~ov.pin_value_override_en & ov.port_data);
	assign ov.pin_ie     = (ov.input_en_override_en & ov.input_en_override_val) | ~ov.input_en_override_en;
endmodule

// [verilog/pcd_alt_mux.sv]
// How it works
// - External memory with mask below 5,6,7,7 drives port C bits 3..0 with address 11..8.
// - Port C bit 6 drives test data out when scan enabled, else address 14 when external memory is on with mask below 2.
// - Port C low input override to one when group enable and pin mask set.
// - Synced port C inputs feed pin-change lines; bits 7,5,4 feed the scan port.
// - Async timer-2 select cuts port D bit 5 from all port logic.
// - Async timer-2 select cuts port D bit 4 from all port logic.
// - Compare 1A reaches port D bit 5 only when its direction bit is output.
// - Serial 0 clock on port D bit 4 follows that pin's direction bit.
// - Serial 0 clock pin claimed only in serial 0 synchronous mode.
// - Compare 3A reaches port D bit 4 only when its direction bit is output.
// - Port D bit 3 feeds external interrupt 1 and capture 3.
// - Port D bit 2 feeds external interrupt 0.
// - Serial 1 clock on port D bit 2 follows direction, only in synchronous mode.
// - Serial 0 transmit enable forces port D bit 1 output with transmit data.
// - Port D bits 7 and 6 carry memory read and write strobes.
// - Serial 0 receive enable forces port D bit 0 input, pull-up from data bit.
//
// Chosen here: register access over Wishbone and the placing of the registers.
module pcd_alt_mux (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic [pcd_pkg::PORT_W-1:0] port_c_data_i,
	input  wire logic [pcd_pkg::PORT_W-1:0] port_c_dir_i,
	input  wire logic [pcd_pkg::PORT_W-1:0] port_d_data_i,
	input  wire logic [pcd_pkg::PORT_W-1:0] port_d_dir_i,
	input  wire logic [pcd_pkg::PORT_W-1:0] pin_c_i,
	input  wire logic [pcd_pkg::PORT_W-1:0] pin_d_i,
	input  wire logic [15:8]               ext_addr_i,
	input  wire logic                      ext_rd_strobe_i,
	input  wire logic                      ext_wr_strobe_i,
	input  wire logic                      scan_tdo_i,
	input  wire logic                      cmp1a_en_i,
	input  wire logic                      cmp1a_out_i,
	input  wire logic                      cmp3a_en_i,
	input  wire logic                      cmp3a_out_i,
	input  wire logic                      serial0_sync_i,
	input  wire logic                      serial0_ext_clk_i,
	input  wire logic                      serial1_sync_i,
	input  wire logic                      serial1_ext_clk_i,
	input  wire logic                      serial0_tx_en_i,
	input  wire logic                      serial0_tx_i,
	input  wire logic                      serial0_rx_en_i,
	input  wire logic                      ext_irq0_en_i,
	input  wire logic                      ext_irq1_en_i,
	output logic      [pcd_pkg::PORT_W-1:0] pc_out_o,
	output logic      [pcd_pkg::PORT_W-1:0] pc_oe_o,
	output logic      [pcd_pkg::PORT_W-1:0] pc_pullup_o,
	output logic      [pcd_pkg::PORT_W-1:0] pd_out_o,
	output logic      [pcd_pkg::PORT_W-1:0] pd_oe_o,
	output logic      [pcd_pkg::PORT_W-1:0] pd_pullup_o,
	output logic      [pcd_pkg::PORT_W-1:0] pin_change_line_o,
	output logic                           scan_tdi_o,
	output logic                           scan_tms_o,
	output logic                           scan_tck_o,
	output logic                           ext_irq0_in_o,
	output logic                           ext_irq1_in_o,
	output logic                           capture3_in_o,
	output logic                           serial0_rx_o,
	output logic                           serial0_ext_clk_in_o,
	output logic                           serial1_ext_clk_in_o
);
	import pcd_pkg::*;

	logic [7:0]  ctrl;
	logic [7:0]  pc_mask;
	logic [7:0]  c_s1, c_s2, c_s3, c_filt;
	logic [7:0]  d_s1, d_s2, d_s3, d_filt;
	wire  [7:0]  next_c_filt, next_d_filt;
	wire  [7:0]  c_di, d_di;
	wire         wb_req, wb_wr, sel_ctrl, sel_mask, sel_pins;
	wire  [31:0] next_rdata;
	wire         xmem_en, scan_en, async_t2, pcg1_en, pull_dis;
	wire  [2:0]  ext_mem_high_mask;
	wire         serial0_ext_clk_oe, serial1_ext_clk_oe;
	logic        rst_held;

	pcd_ovr_if c_if ();
	pcd_ovr_if d_if ();

	pcd_ovr_mux u_mux_c (
		.ov (c_if.mux)
	);
	pcd_ovr_mux u_mux_d (
		.ov (d_if.mux)
	);

	// Register slave decode; every access is acknowledged one cycle after it is seen.
	assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
	assign sel_ctrl = (wb_adr_i == REG_CTRL);
	assign sel_mask = (wb_adr_i == REG_PCMASK);
	assign sel_pins = (wb_adr_i == REG_PINS);
	assign next_rdata = sel_ctrl ? {24'h00_0000, ctrl} :
	                    sel_mask ? {24'h00_0000, pc_mask} :
	                    sel_pins ? {16'h0000, d_filt, c_filt} : DATA_ZERO;

	// Control fields.
	assign xmem_en  = ctrl[CTRL_XMEM_EN];
	assign ext_mem_high_mask      = ctrl[CTRL_XMM_HI:CTRL_XMM_LO];
	assign scan_en  = ctrl[CTRL_SCAN_EN];
	assign async_t2 = ctrl[CTRL_ASYNC_T2];
	assign pcg1_en  = ctrl[CTRL_PCG1_EN];
	assign pull_dis = ctrl[CTRL_PULL_DIS];

	// Bus register writes, byte lane 0 only; other lanes are ignored.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= CTRL_RST;
			pc_mask  <= PCMASK_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= DATA_ZERO;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : DATA_ZERO;
			if (wb_wr && sel_ctrl) begin
				ctrl <= wb_dat_i[7:0];
			end
			if (wb_wr && sel_mask) begin
				pc_mask <= wb_dat_i[7:0];
			end
		end
	end

	// A pin change counts only once the second and third stages agree.
	assign next_c_filt = ((c_s2 ~^ c_s3) & c_s3) | ((c_s2 ^ c_s3) & c_filt);
	assign next_d_filt = ((d_s2 ~^ d_s3) & d_s3) | ((d_s2 ^ d_s3) & d_filt);

	// Pin input synchronisers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{c_s1, c_s2, c_s3, c_filt} <= {4{PORT_RST}};
			{d_s1, d_s2, d_s3, d_filt} <= {4{PORT_RST}};
		end else begin
			{c_s1, c_s2, c_s3, c_filt} <= {pin_c_i, c_s1, c_s2, next_c_filt};
			{d_s1, d_s2, d_s3, d_filt} <= {pin_d_i, d_s1, d_s2, next_d_filt};
		end
	end

	// Disabled inputs read as zero.
	assign c_di = c_filt & c_if.pin_ie;
	assign d_di = d_filt & d_if.pin_ie;

	// Port register values for both muxes.
	assign c_if.port_data = port_c_data_i;
	assign c_if.port_dir  = port_c_dir_i;
	assign c_if.pull_dis  = pull_dis;
	assign d_if.port_data = port_d_data_i;
	assign d_if.port_dir  = port_d_dir_i;
	assign d_if.pull_dis  = pull_dis;

	// Port C overrides, one slice per pin.
	for (genvar i = 0; i < PORT_W; i++) begin : g_pc
		wire xm_own;
		wire hi_pin;
		assign hi_pin = (i >= PC_TCK);
		assign xm_own = xmem_en & ({1'b0, ext_mem_high_mask} < PC_MASK_LIMIT[i]);
		assign c_if.pullup_override_en[i]  = xm_own | (hi_pin & scan_en);
		assign c_if.pullup_override_val[i] = hi_pin & scan_en;
		// Address pins are outputs; scan pins are inputs except test data out.
		assign c_if.dir_override_en[i]  = xm_own | (hi_pin & scan_en);
		assign c_if.dir_override_val[i] = (hi_pin & scan_en) ? (i == PC_TDO) : 1'b1;
		assign c_if.pin_value_override_en[i]  = xm_own | ((i == PC_TDO) & scan_en);
		assign c_if.pin_value_override_val[i] = ((i == PC_TDO) & scan_en) ? scan_tdo_i : ext_addr_i[8 + i];
		assign c_if.input_en_override_en[i]  = (hi_pin & scan_en) | (pcg1_en & pc_mask[i]);
		assign c_if.input_en_override_val[i] = hi_pin ? scan_en : 1'b1;
	end

	// serial clocks claim pins only in synchronous mode with output direction
	assign serial0_ext_clk_oe = serial0_sync_i & port_d_dir_i[PD_OSCI];
	assign serial1_ext_clk_oe = serial1_sync_i & port_d_dir_i[PD_IRQ0];

	// Port D overrides, packed from bit 7 down to bit 0.
	// ownership of pull-up and direction
	assign d_if.pullup_override_en  = {xmem_en, xmem_en, async_t2, async_t2, 2'b00, serial0_tx_en_i,
	                                   serial0_rx_en_i};
	assign d_if.pullup_override_val = {7'h00, port_d_data_i[PD_RX] & ~pull_dis};
	assign d_if.dir_override_en     = {xmem_en, xmem_en, async_t2, async_t2, 2'b00, serial0_tx_en_i,
	                                   serial0_rx_en_i};
	assign d_if.dir_override_val    = {2'b11, 4'h0, 2'b10};
	// compare outputs and serial clocks go out through the direction bit
	assign d_if.pin_value_override_en  = {xmem_en, xmem_en, cmp1a_en_i & ~async_t2,
	                                      (serial0_ext_clk_oe | cmp3a_en_i) & ~async_t2, 1'b0, serial1_ext_clk_oe,
	                                      serial0_tx_en_i, 1'b0};
	assign d_if.pin_value_override_val = {ext_rd_strobe_i, ext_wr_strobe_i, cmp1a_out_i,
	                                      serial0_ext_clk_oe ? serial0_ext_clk_i : cmp3a_out_i, 1'b0,
	                                      serial1_ext_clk_i, serial0_tx_i, 1'b0};
	// interrupt inputs keep their input buffers on
	assign d_if.input_en_override_en  = {2'b00, async_t2, async_t2, ext_irq1_en_i, ext_irq0_en_i, 2'b00};
	assign d_if.input_en_override_val = {4'h0, 2'b11, 2'b00};

	// Registered pin drive and alternate-function inputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{pc_out_o, pc_oe_o, pc_pullup_o} <= {3{PORT_RST}};
			{pd_out_o, pd_oe_o, pd_pullup_o} <= {3{PORT_RST}};
			pin_change_line_o <= PORT_RST;
			{scan_tdi_o, scan_tms_o, scan_tck_o} <= 3'b000;
			{ext_irq0_in_o, ext_irq1_in_o, capture3_in_o} <= 3'b000;
			{serial0_rx_o, serial0_ext_clk_in_o, serial1_ext_clk_in_o} <= 3'b000;
		end else begin
			{pc_out_o, pc_oe_o, pc_pullup_o} <= {c_if.pin_out, c_if.pin_oe, c_if.pin_pullup};
			{pd_out_o, pd_oe_o, pd_pullup_o} <= {d_if.pin_out, d_if.pin_oe, d_if.pin_pullup};
			pin_change_line_o <= c_di;
			{scan_tdi_o, scan_tms_o, scan_tck_o} <= {c_di[PC_TDI], c_di[PC_TMS], c_di[PC_TCK]};
			{ext_irq0_in_o, ext_irq1_in_o, capture3_in_o} <= {d_di[PD_IRQ0], d_di[PD_IRQ1], d_di[PD_IRQ1]};
			serial0_rx_o <= d_di[PD_RX];
			// serial clock inputs only when not driving
			serial0_ext_clk_in_o <= d_di[PD_OSCI] & serial0_sync_i & ~port_d_dir_i[PD_OSCI];
			serial1_ext_clk_in_o <= d_di[PD_IRQ0] & serial1_sync_i & ~port_d_dir_i[PD_IRQ0];
		end
	end

	// Reset seen one edge late; it keeps checks off at the edge where reset is released.
	always_ff @(posedge clk_i) begin
		rst_held <= rst_i;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || rst_held);

	sequence s_irq1_held;
		(pin_d_i[PD_IRQ1] && ext_irq1_en_i && !async_t2) [*5];
	endsequence
	sequence s_pc7_held;
		(pin_c_i[PC_TDI] && scan_en) [*5];
	endsequence

	property p_xmem_c7;
		(xmem_en && ext_mem_high_mask == 3'h0 && !scan_en) |=> (pc_oe_o[7] && pc_out_o[7] == $past(ext_addr_i[15]));
	endproperty
	a_xmem_c7: assert property (p_xmem_c7) else $error("Port C bit 7 not driven by address 15.");

	property p_xmem_c1_off;
		(xmem_en && ext_mem_high_mask == 3'h7 && !port_c_dir_i[1]) |=> !pc_oe_o[1];
	endproperty
	a_xmem_c1_off: assert property (p_xmem_c1_off) else $error("Port C bit 1 claimed at full mask.");

	property p_tdo;
		scan_en |=> (pc_oe_o[PC_TDO] && pc_out_o[PC_TDO] == $past(scan_tdo_i));
	endproperty
	a_tdo: assert property (p_tdo) else $error("Test data out not on port C bit 6.");

	property p_scan_pullup;
		scan_en |=> (pc_pullup_o[7:4] == 4'hF);
	endproperty
	a_scan_pullup: assert property (p_scan_pullup) else $error("Scan pins lost pull-ups.");

	property p_tdi_path;
		s_pc7_held |-> ##[0:3] scan_tdi_o;
	endproperty
	a_tdi_path: assert property (p_tdi_path) else $error("Test data in did not follow pin.");

	property p_async_cut;
		async_t2 |=> (pd_oe_o[5:4] == 2'b00 && pd_pullup_o[5:4] == 2'b00);
	endproperty
	a_async_cut: assert property (p_async_cut) else $error("Oscillator pins still driven.");

	property p_irq1;
		s_irq1_held |-> ##[0:3] (ext_irq1_in_o && capture3_in_o);
	endproperty
	a_irq1: assert property (p_irq1) else $error("Interrupt 1 or capture 3 missed pin.");

	property p_tx;
		serial0_tx_en_i |=> (pd_oe_o[PD_TX] && pd_out_o[PD_TX] == $past(serial0_tx_i));
	endproperty
	a_tx: assert property (p_tx) else $error("Transmit pin not forced out.");

	property p_rx;
		serial0_rx_en_i |=> (!pd_oe_o[PD_RX] && pd_pullup_o[PD_RX] == $past(port_d_data_i[PD_RX] & ~pull_dis));
	endproperty
	a_rx: assert property (p_rx) else $error("Receive pin not forced in.");

	property p_rd_strobe;
		xmem_en |=> (pd_oe_o[PD_RD] && pd_out_o[PD_RD] == $past(ext_rd_strobe_i));
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("Read strobe not on port D bit 7.");

	property p_osc_in_cut;
		async_t2 |=> !serial0_ext_clk_in_o;
	endproperty
	a_osc_in_cut: assert property (p_osc_in_cut) else $error("Oscillator input still feeds logic.");

	property p_cmp1a_dir;
		(!async_t2 && !port_d_dir_i[PD_OSCO]) |=> !pd_oe_o[PD_OSCO];
	endproperty
	a_cmp1a_dir: assert property (p_cmp1a_dir) else $error("Port D bit 5 driven as input.");

	property p_serial0_ext_clk_async;
		!serial0_sync_i |=> !serial0_ext_clk_in_o;
	endproperty
	a_serial0_ext_clk_async: assert property (p_serial0_ext_clk_async) else $error("Serial 0 clock claimed off sync.");

	property p_serial1_ext_clk_out;
		(serial1_sync_i && port_d_dir_i[PD_IRQ0])
			|=> (pd_oe_o[PD_IRQ0] && pd_out_o[PD_IRQ0] == $past(serial1_ext_clk_i));
	endproperty
	a_serial1_ext_clk_out: assert property (p_serial1_ext_clk_out) else $error("Serial 1 clock not driven out.");

endmodule

// [test/pcd_pin_model.sv]
module pcd_pin_model (
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] out_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A pin shows the device level where it drives, the outside party's level elsewhere.
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// [test/port_c_d_alt_function_override_bench.sv]
module port_c_d_alt_function_override_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pcd_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = 8'h00, cdat = 8'h00, cdir = 8'h00, ddat = 8'h00, ddir = 8'h00;
	logic [7:0] ext_c = 8'h00, ext_d = 8'h00, pin_c, pin_d, addr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic rd = 0, wr = 0, tdo = 0, c1e = 0, c1o = 0, c3e = 0, c3o = 0, s0s = 0, s0c = 0;
	logic s1s = 0, s1c = 0, txe = 0, tx = 0, rxe = 0, i0e = 0, i1e = 0;
	logic [7:0] pc_out, pc_oe, pc_pu, pd_out, pd_oe, pd_pu, pcl;
	logic tdi, tms, tck, irq0, irq1, cap3, rx, s0ci, s1ci;
	int n_fail = 0, total_checks = 0;

	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 clk_i = ~clk_i;

	pcd_pin_model pc_u (.oe_i(pc_oe), .out_i(pc_out), .ext_i(ext_c), .pin_o(pin_c));
	pcd_pin_model pd_u (.oe_i(pd_oe), .out_i(pd_out), .ext_i(ext_d), .pin_o(pin_d));

	pcd_alt_mux dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.port_c_data_i(cdat), .port_c_dir_i(cdir), .port_d_data_i(ddat), .port_d_dir_i(ddir),
		.pin_c_i(pin_c), .pin_d_i(pin_d), .ext_addr_i(addr), .ext_rd_strobe_i(rd), .ext_wr_strobe_i(wr),
		.scan_tdo_i(tdo), .cmp1a_en_i(c1e), .cmp1a_out_i(c1o), .cmp3a_en_i(c3e), .cmp3a_out_i(c3o),
		.serial0_sync_i(s0s), .serial0_ext_clk_i(s0c), .serial1_sync_i(s1s), .serial1_ext_clk_i(s1c),
		.serial0_tx_en_i(txe), .serial0_tx_i(tx), .serial0_rx_en_i(rxe), .ext_irq0_en_i(i0e),
		.ext_irq1_en_i(i1e), .pc_out_o(pc_out), .pc_oe_o(pc_oe), .pc_pullup_o(pc_pu), .pd_out_o(pd_out),
		.pd_oe_o(pd_oe), .pd_pullup_o(pd_pu), .pin_change_line_o(pcl), .scan_tdi_o(tdi), .scan_tms_o(tms),
		.scan_tck_o(tck), .ext_irq0_in_o(irq0), .ext_irq1_in_o(irq1), .capture3_in_o(cap3),
		.serial0_rx_o(rx), .serial0_ext_clk_in_o(s0ci), .serial1_ext_clk_in_o(s1ci));

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one result with its expected value.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Lets n edges pass and steps off the edge.
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// One classic bus cycle; the request holds until ack is sampled high at a rising edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			n_fail++;
			$display("[FAIL] bus ack expected 1 seen none");
			tally_and_finish();
		end
	endtask

	initial begin
		logic [31:0] q;
		logic [7:0] ov, ep, ed, r, dd;
		int lim;
		void'($urandom(84656));
		settle(4);
		chk("oe during reset", 32'h0, {pc_oe, pd_oe, 7'h0, ack});
		@(posedge clk_i);
		rst_i <= 1'b0;
		// Address drive across every mask value, with random port registers behind it.
		for (int m = 0; m < 8; m++) begin
			@(posedge clk_i);
			cdir <= 8'($urandom);
			cdat <= 8'($urandom);
			addr <= 8'($urandom);
			rd <= 1'($urandom);
			wr <= 1'($urandom);
			wb(1'b1, REG_CTRL, 32'((m << 1) | 1), q);
			settle(2);
			ov = 8'h00;
			for (int i = 0; i < 8; i++) begin
				lim = (i >= 4) ? 8 - i : (i == 3) ? 5 : (i == 2) ? 6 : 7;
				ov[i] = (m < lim);
			end
			chk("pc_oe_o", ov | cdir, pc_oe);
			chk("pc_out_o", (ov & addr) | (~ov & cdat), pc_out);
			chk("pc_pullup_o", 32'h0, pc_pu & ov);
			chk("pd strobes", {2'b11, rd, wr}, {pd_oe[7:6], pd_out[7:6]});
		end
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk("ctrl read", 32'h0F, q);
		wb(1'b0, 8'h0C, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		$display("test address drive done");
		// Scan port takes the high port C pins.
		ep = 8'($urandom);
		@(posedge clk_i);
		cdir <= 8'h00;
		ext_c <= ep;
		tdo <= ep[6];
		addr[6] <= ~ep[6];
		wb(1'b1, REG_CTRL, 32'h10, q);
		settle(8);
		chk("tdo pin", {1'b1, ep[6]}, {pc_oe[6], pc_out[6]});
		chk("scan pullups", 32'hF, pc_pu[7:4]);
		chk("pin change hi", ep[7:4], pcl[7:4]);
		chk("scan inputs", {ep[7], ep[5], ep[4]}, {tdi, tms, tck});
		// Pin-change group without scan: high inputs off, low inputs on.
		wb(1'b1, REG_PCMASK, 32'hFF, q);
		wb(1'b1, REG_CTRL, 32'h40, q);
		settle(8);
		chk("pin change lines", {4'h0, ep[3:0]}, pcl);
		wb(1'b0, REG_PINS, 32'h0, q);
		chk("pins read", ep, q[7:0]);
		$display("test scan and pin change done");
		// Port D functions with their direction bits.
		ed = 8'($urandom);
		r = 8'($urandom);
		dd = 8'($urandom);
		@(posedge clk_i);
		ext_d <= ed;
		ddir <= 8'h34;
		ddat <= dd;
		{c1e, c1o, c3e, c3o} <= {1'b1, r[0], 1'b1, r[1]};
		{s1s, s1c, txe, tx, rxe, i0e, i1e} <= {1'b1, r[2], 1'b1, r[3], 3'b111};
		wb(1'b1, REG_CTRL, 32'h0, q);
		settle(8);
		chk("pd_oe_o", 32'h36, pd_oe & 8'h3F);
		chk("pd_out_o", {2'b0, r[0], r[1], 1'b0, r[2], r[3], 1'b0}, pd_out & 8'h36);
		chk("irq1 capture", {ed[3], ed[3]}, {irq1, cap3});
		chk("irq0", r[2], irq0);
		chk("rx", {ed[0], dd[0]}, {rx, pd_pu[0]});
		wb(1'b1, REG_CTRL, 32'h80, q);
		settle(2);
		chk("rx pullup disabled", 32'h0, pd_pu[0]);
		wb(1'b1, REG_CTRL, 32'h20, q);
		settle(2);
		chk("osc pins", 32'h0, {pd_oe[5:4], pd_pu[5:4]});
		$display("test port d done");
		// Serial clocks as inputs, then serial 0 clock as output.
		@(posedge clk_i);
		ddir <= 8'h00;
		s0s <= 1'b1;
		s0c <= ~ed[4];
		c3o <= ed[4];
		wb(1'b1, REG_CTRL, 32'h0, q);
		settle(8);
		chk("clk inputs", {ed[4], ed[2]}, {s0ci, s1ci});
		@(posedge clk_i);
		s0s <= 1'b0;
		settle(2);
		chk("clk0 async mode", 32'h0, s0ci);
		@(posedge clk_i);
		s0s <= 1'b1;
		ddir <= 8'h10;
		settle(2);
		chk("clk0 out", {1'b1, ~ed[4], 1'b0}, {pd_oe[4], pd_out[4], s0ci});
		$display("test serial clocks done");
		// Reset in mid-run clears every output and the control register.
		@(posedge clk_i);
		rst_i <= 1'b1;
		settle(2);
		chk("oe in mid-run reset", 32'h0, {pc_oe, pd_oe, 7'h0, ack});
		@(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk("ctrl after reset", 32'h0, q);
		settle(2);
		chk("tx after reset", {1'b1, tx}, {pd_oe[PD_TX], pd_out[PD_TX]});
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
